// ===== verilog/sic_defs.vh
// Function
// - Async serial stops in deep idle, ch0 external-clock exception
// - Clocked serial runs only on external clock in deep idle and stop
// - Converters hold operation and results in deep idle
// - Port pins hold their state in deep idle
// - Internal data and RAM preserved in deep idle
// - Interrupt wake starts stabilization timer, resume on overflow
// - Reset wake waits the reset default stabilization
// - Stop entry from normal, select 01/11, request bit
// - Stop halts main oscillator, gates CPU and peripherals
// - Subclock and external-clock peripherals keep running
// - Pending unmasked interrupt releases standby at once
// - Stop wake sources; clock monitor excluded
// - Stop release waits stabilization before normal
// - Masked sources in control register never wake
// - Lower priority wakes unacknowledged, higher acknowledged
`ifndef SIC_DEFS_VH
`define SIC_DEFS_VH

// Register word offsets (byte addresses)
`define SIC_OFF_PMS 4'h0
`define SIC_OFF_PSC 4'h4
`define SIC_OFF_STABILIZATION_TIME_SELECT 4'h8
`define SIC_OFF_STAT 4'hc

// Power mode select field codes
`define SIC_PSM_STOP_A 2'h1
`define SIC_PSM_STOP_B 2'h3
`define SIC_PSM_DIDLE 2'h2
`define SIC_PMS_RST 2'h0

// Power save control bit positions
`define SIC_PSC_STOP_REQ 1
`define SIC_PSC_MASKABLE_MSK 4
`define SIC_PSC_NM0_MSK 5
`define SIC_PSC_NM1_MSK 6
`define SIC_PSC_RST 3'h0

// Stabilization select
`define SIC_STABILIZATION_TIME_SELECT_W 3
`define SIC_STABILIZATION_TIME_SELECT_RST 3'h6
`define SIC_STAB_EXP_BASE 10
`define SIC_EXP_W 5

// Status register bit positions
`define SIC_STAT_STATE_LSB 0
`define SIC_STAT_BUSY 3
`define SIC_STAT_NMI_WAKE 4
`define SIC_STAT_DEFER 5

`endif

// ===== verilog/sic_stab_timer.v
`include "sic_defs.vh"

module sic_stab_timer #(
  parameter CNT_W = 18
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [`SIC_EXP_W-1:0] exp_in,
  output reg busy_out,
  output reg done_out
);

  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] limit_q;

  // All ones below bit e: the count at which the timer overflows
  function [CNT_W-1:0] ovf_mask;
    input [`SIC_EXP_W-1:0] e;
    integer i;
    begin
      ovf_mask = {CNT_W{1'b0}};
      for (i = 0; i < CNT_W; i = i + 1) begin
        if (i < e) begin
          ovf_mask[i] = 1'b1;
        end
      end
    end
  endfunction

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= {CNT_W{1'b0}};
      limit_q <= {CNT_W{1'b0}};
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_q <= {CNT_W{1'b0}};
        limit_q <= ovf_mask(exp_in);
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt_q == limit_q) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // sic_stab_timer

// ===== verilog/sic_standby_ctrl.v
// Implementation choices: the register offsets and the strobed register port.
`include "sic_defs.vh"

module sic_standby_ctrl #(
  parameter STAB_EXP_BASE = `SIC_STAB_EXP_BASE,
  parameter CNT_W = 18,
  parameter N_EXT_IRQ = 8,
  parameter N_CSI = 5
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire nmi_pin_in,
  input wire watchdog_nonmask_irq_in,
  input wire [N_EXT_IRQ-1:0] external_irq_inputs_in,
  input wire periph_irq_in,
  input wire watchdog_reset_in,
  input wire low_voltage_detector_in,
  input wire clock_monitor_in,
  input wire in_service_in,
  input wire higher_prio_in,
  input wire async_serial_ext_clock_sel_in,
  input wire [N_CSI-1:0] clocked_serial_ext_clock_sel_in,
  output reg main_osc_en_out,
  output reg sub_osc_en_out,
  output reg cpu_clk_en_out,
  output reg periph_clk_en_out,
  output reg sub_periph_clk_en_out,
  output reg async_serial_ch0_clk_en_out,
  output reg async_serial_other_clk_en_out,
  output reg two_wire_clk_en_out,
  output reg [N_CSI-1:0] clocked_serial_channels_clk_en_out,
  output reg converter_hold_out,
  output reg port_hold_out,
  output reg data_retain_out,
  output reg internal_reset_out,
  output reg irq_ack_grant_out,
  output reg irq_ack_defer_out
);

  localparam ST_NORMAL = 3'h0;
  localparam ST_ENTER = 3'h1;
  localparam ST_DIDLE = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_STAB = 3'h4;
  localparam ST_RSTAB = 3'h5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] power_mode_select_reg_q;
  reg [2:0] power_save_control_reg_q;
  reg [`SIC_STABILIZATION_TIME_SELECT_W-1:0] stabilization_time_select_q;
  reg stop_mode_q;
  reg nmi_wake_q;
  reg defer_q;
  reg start_q;
  reg [`SIC_EXP_W-1:0] exp_q;
  reg [7:0] rdata_d;

  wire power_mode_sel_hi = power_mode_select_reg_q[1];
  wire power_mode_sel_lo = power_mode_select_reg_q[0];
  wire maskable_wake_mask = power_save_control_reg_q[0];
  wire nonmask_src0_mask = power_save_control_reg_q[1];
  wire nonmask_src1_mask = power_save_control_reg_q[2];
  wire stab_busy;
  wire stab_done;

  wire wr_psc = reg_wr_in && (reg_addr_in == `SIC_OFF_PSC);
  wire stop_req = wr_psc && reg_wdata_in[`SIC_PSC_STOP_REQ];
  wire sel_stop = ({power_mode_sel_hi, power_mode_sel_lo} == `SIC_PSM_STOP_A) ||
    ({power_mode_sel_hi, power_mode_sel_lo} == `SIC_PSM_STOP_B);
  wire sel_didle = ({power_mode_sel_hi, power_mode_sel_lo} == `SIC_PSM_DIDLE);

  // Masked sources are dropped before they can release standby
  wire nmi_wake = (nmi_pin_in && !nonmask_src0_mask) ||
    (watchdog_nonmask_irq_in && !nonmask_src1_mask);
  wire mask_wake = !maskable_wake_mask &&
    ((|external_irq_inputs_in) || periph_irq_in);
  wire irq_wake = nmi_wake || mask_wake;

  // Clock monitor cannot act while the main oscillator is halted
  wire cm_reset = clock_monitor_in && (state_q != ST_STOP);
  wire int_reset = watchdog_reset_in || low_voltage_detector_in ||
    cm_reset;

  // Stabilization exponent for a given select value
  function [`SIC_EXP_W-1:0] stab_exp;
    input [`SIC_STABILIZATION_TIME_SELECT_W-1:0] sel;
    begin
      stab_exp = STAB_EXP_BASE[`SIC_EXP_W-1:0] +
        {{(`SIC_EXP_W-`SIC_STABILIZATION_TIME_SELECT_W){1'b0}}, sel};
    end
  endfunction

  // One counter serves every stabilization wait
  sic_stab_timer #(
    .CNT_W(CNT_W)
  ) u_stab (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_q),
    .exp_in(exp_q),
    .busy_out(stab_busy),
    .done_out(stab_done)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (stop_req && (sel_stop || sel_didle)) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // One cycle of grace; the no-ops after the store run out here
        if (irq_wake) begin
          state_d = ST_STAB;
        end else if (stop_mode_q) begin
          state_d = ST_STOP;
        end else begin
          state_d = ST_DIDLE;
        end
      end
      ST_DIDLE: begin
        if (irq_wake) begin
          state_d = ST_STAB;
        end
      end
      ST_STOP: begin
        if (irq_wake) begin
          state_d = ST_STAB;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_d = ST_NORMAL;
        end
      end
      ST_RSTAB: begin
        if (stab_done) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
    if (int_reset) begin
      state_d = ST_RSTAB;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_RSTAB;
      start_q <= 1'b1;
      exp_q <= {`SIC_EXP_W{1'b0}};
      stop_mode_q <= 1'b0;
      nmi_wake_q <= 1'b0;
      defer_q <= 1'b0;
      internal_reset_out <= 1'b1;
      irq_ack_grant_out <= 1'b0;
      irq_ack_defer_out <= 1'b0;
    end else begin
      state_q <= state_d;
      internal_reset_out <= int_reset;
      irq_ack_grant_out <= 1'b0;
      irq_ack_defer_out <= 1'b0;
      start_q <= 1'b0;
      if (state_q == ST_RSTAB && exp_q == {`SIC_EXP_W{1'b0}}) begin
        // The pin-reset start ran with a zero exponent, so start again
        // once the reset select is loaded
        start_q <= 1'b1;
        exp_q <= stab_exp(`SIC_STABILIZATION_TIME_SELECT_RST);
      end
      if (int_reset) begin
        start_q <= 1'b1;
        exp_q <= stab_exp(`SIC_STABILIZATION_TIME_SELECT_RST);
        nmi_wake_q <= 1'b0;
        defer_q <= 1'b0;
      end else if (state_d == ST_STAB && state_q != ST_STAB) begin
        start_q <= 1'b1;
        exp_q <= stab_exp(stabilization_time_select_q);
        nmi_wake_q <= nmi_wake;
        defer_q <= in_service_in && !higher_prio_in && !nmi_wake;
      end
      // Remember which standby was asked for, for the enter cycle
      if (state_q == ST_NORMAL && state_d == ST_ENTER) begin
        stop_mode_q <= sel_stop;
      end
      // Acknowledge leaves with the resume; outranked requests wait
      if (state_q == ST_STAB && stab_done) begin
        irq_ack_grant_out <= !defer_q;
        irq_ack_defer_out <= defer_q;
      end
    end
  end

  // Internal resets return the settings to defaults, as the pin does

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_mode_select_reg_q <= `SIC_PMS_RST;
      power_save_control_reg_q <= `SIC_PSC_RST;
      stabilization_time_select_q <= `SIC_STABILIZATION_TIME_SELECT_RST;
    end else if (int_reset) begin
      power_mode_select_reg_q <= `SIC_PMS_RST;
      power_save_control_reg_q <= `SIC_PSC_RST;
      stabilization_time_select_q <= `SIC_STABILIZATION_TIME_SELECT_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `SIC_OFF_PMS) begin
        power_mode_select_reg_q <= reg_wdata_in[1:0];
      end else if (reg_addr_in == `SIC_OFF_PSC) begin
        power_save_control_reg_q <= {reg_wdata_in[`SIC_PSC_NM1_MSK],
          reg_wdata_in[`SIC_PSC_NM0_MSK],
          reg_wdata_in[`SIC_PSC_MASKABLE_MSK]};
      end else if (reg_addr_in == `SIC_OFF_STABILIZATION_TIME_SELECT) begin
        stabilization_time_select_q <= reg_wdata_in[`SIC_STABILIZATION_TIME_SELECT_W-1:0];
      end
    end
  end

  // Read mux; the stop request bit is a trigger and reads as zero
  always @* begin
    rdata_d = 8'h00;
    if (reg_addr_in == `SIC_OFF_PMS) begin
      rdata_d[1:0] = power_mode_select_reg_q;
    end else if (reg_addr_in == `SIC_OFF_PSC) begin
      rdata_d[`SIC_PSC_MASKABLE_MSK] = maskable_wake_mask;
      rdata_d[`SIC_PSC_NM0_MSK] = nonmask_src0_mask;
      rdata_d[`SIC_PSC_NM1_MSK] = nonmask_src1_mask;
    end else if (reg_addr_in == `SIC_OFF_STABILIZATION_TIME_SELECT) begin
      rdata_d[`SIC_STABILIZATION_TIME_SELECT_W-1:0] = stabilization_time_select_q;
    end else if (reg_addr_in == `SIC_OFF_STAT) begin
      rdata_d[`SIC_STAT_STATE_LSB+2:`SIC_STAT_STATE_LSB] = state_q;
      rdata_d[`SIC_STAT_BUSY] = stab_busy;
      rdata_d[`SIC_STAT_NMI_WAKE] = nmi_wake_q;
      rdata_d[`SIC_STAT_DEFER] = defer_q;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Gating outputs follow the next state so they change with state_q
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      main_osc_en_out <= 1'b1;
      sub_osc_en_out <= 1'b1;
      cpu_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      sub_periph_clk_en_out <= 1'b1;
      async_serial_ch0_clk_en_out <= 1'b0;
      async_serial_other_clk_en_out <= 1'b0;
      two_wire_clk_en_out <= 1'b0;
      clocked_serial_channels_clk_en_out <= {N_CSI{1'b0}};
      converter_hold_out <= 1'b0;
      port_hold_out <= 1'b0;
      data_retain_out <= 1'b0;
    end else begin
      main_osc_en_out <= (state_d != ST_STOP);
      sub_osc_en_out <= 1'b1;
      sub_periph_clk_en_out <= 1'b1;
      cpu_clk_en_out <= (state_d == ST_NORMAL) ||
        (state_d == ST_ENTER);
      periph_clk_en_out <= (state_d == ST_NORMAL) ||
        (state_d == ST_ENTER);
      two_wire_clk_en_out <= (state_d == ST_NORMAL) ||
        (state_d == ST_ENTER);
      async_serial_other_clk_en_out <= (state_d == ST_NORMAL) ||
        (state_d == ST_ENTER);
      if (state_d == ST_DIDLE || state_d == ST_STOP) begin
        async_serial_ch0_clk_en_out <= async_serial_ext_clock_sel_in;
        clocked_serial_channels_clk_en_out <=
          clocked_serial_ext_clock_sel_in;
        converter_hold_out <= 1'b1;
        port_hold_out <= 1'b1;
        data_retain_out <= 1'b1;
      end else begin
        async_serial_ch0_clk_en_out <= (state_d == ST_NORMAL) ||
          (state_d == ST_ENTER);
        clocked_serial_channels_clk_en_out <= {N_CSI{
          (state_d == ST_NORMAL) || (state_d == ST_ENTER)}};
        converter_hold_out <= 1'b0;
        port_hold_out <= 1'b0;
        data_retain_out <= 1'b0;
      end
    end
  end

endmodule // sic_standby_ctrl

// ===== bench/sic_standby_ctrl_checker.sv
module sic_standby_ctrl_checker #(
  parameter N_CSI = 5
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire async_serial_ext_clock_sel_in,
  input wire [N_CSI-1:0] clocked_serial_ext_clock_sel_in,
  input wire main_osc_en_out,
  input wire sub_osc_en_out,
  input wire cpu_clk_en_out,
  input wire periph_clk_en_out,
  input wire sub_periph_clk_en_out,
  input wire async_serial_ch0_clk_en_out,
  input wire async_serial_other_clk_en_out,
  input wire two_wire_clk_en_out,
  input wire [N_CSI-1:0] clocked_serial_channels_clk_en_out,
  input wire converter_hold_out,
  input wire port_hold_out,
  input wire data_retain_out,
  input wire irq_ack_grant_out,
  input wire irq_ack_defer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles since the last stop request write, saturating at 3
  logic [1:0] since_wr_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      since_wr_q <= 2'h3;
    else if (reg_wr_in && reg_addr_in == 4'h4 && reg_wdata_in[1])
      since_wr_q <= 2'h0;
    else if (since_wr_q != 2'h3)
      since_wr_q <= since_wr_q + 2'h1;
  end
  sequence s_ack;
    irq_ack_grant_out || irq_ack_defer_out;
  endsequence
  sequence s_resume;
    $rose(cpu_clk_en_out);
  endsequence
  property p_ack_at_resume;
    s_ack |-> s_resume;
  endproperty
  property p_ack_pulse;
    s_ack |-> !(irq_ack_grant_out && irq_ack_defer_out) ##1
      !(irq_ack_grant_out || irq_ack_defer_out);
  endproperty
  property p_sub_run;
    sub_osc_en_out && sub_periph_clk_en_out;
  endproperty
  property p_stop_gate;
    !main_osc_en_out |-> !cpu_clk_en_out && !periph_clk_en_out &&
      data_retain_out && port_hold_out;
  endproperty
  property p_idle_hold;
    port_hold_out |-> converter_hold_out && data_retain_out && !cpu_clk_en_out;
  endproperty
  property p_idle_serial;
    port_hold_out |-> !two_wire_clk_en_out && !async_serial_other_clk_en_out;
  endproperty
  property p_ch0;
    port_hold_out && $past(port_hold_out) &&
      $stable(async_serial_ext_clock_sel_in) |->
      async_serial_ch0_clk_en_out == async_serial_ext_clock_sel_in;
  endproperty
  property p_csi;
    port_hold_out && $past(port_hold_out) &&
      $stable(clocked_serial_ext_clock_sel_in) |->
      clocked_serial_channels_clk_en_out == clocked_serial_ext_clock_sel_in;
  endproperty
  property p_stop_entry;
    $fell(main_osc_en_out) |-> since_wr_q != 2'h3;
  endproperty
  property p_resume_bound;
    $rose(main_osc_en_out) |-> ##[1:300] cpu_clk_en_out;
  endproperty
  a_ack_at_resume: assert property (p_ack_at_resume) else $error("ack off resume");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse bad");
  a_sub_run: assert property (p_sub_run) else $error("subclock stopped");
  a_stop_gate: assert property (p_stop_gate) else $error("stop gating bad");
  a_idle_hold: assert property (p_idle_hold) else $error("hold bad");
  a_idle_serial: assert property (p_idle_serial) else $error("serial on");
  a_ch0: assert property (p_ch0) else $error("ch0 enable bad");
  a_csi: assert property (p_csi) else $error("clocked serial bad");
  a_stop_entry: assert property (p_stop_entry) else $error("stray stop");
  a_resume_bound: assert property (p_resume_bound) else $error("no resume");
endmodule // sic_standby_ctrl_checker

bind sic_standby_ctrl sic_standby_ctrl_checker #(.N_CSI(N_CSI)) u_chk (.*);

// ===== bench/sic_irq_model.sv
module sic_irq_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [10:0] raise_in,
  input wire logic clear_in,
  input wire logic grant_in,
  output logic [10:0] req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Requests are levels held until taken; a deferred one stays up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      req_out <= 11'h0;
    else if (grant_in || clear_in)
      req_out <= raise_in;
    else
      req_out <= req_out | raise_in;
  end
endmodule // sic_irq_model

// ===== bench/sic_standby_ctrl_tb.sv
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module sic_standby_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_WAIT = 64;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wd_rst = 1'b0;
  logic clkmon = 1'b0;
  logic lvd = 1'b0;
  logic a_sel = 1'b1;
  logic in_srv = 1'b0;
  logic hi_prio = 1'b0;
  logic [4:0] c_sel = 5'h15;
  logic [10:0] raise = 11'h0;
  logic clr = 1'b0;
  logic [10:0] req;
  wire [7:0] rdata;
  wire main_en, sub_en, cpu_en, per_en, sper_en, ch0_en, oth_en, tw_en;
  wire [4:0] csi_en;
  wire conv_h, port_h, retain, int_rst, grant, defer;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  sic_standby_ctrl #(.STAB_EXP_BASE(0)) sic_standby_ctrl_inst (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .nmi_pin_in(req[9]),
    .watchdog_nonmask_irq_in(req[10]), .external_irq_inputs_in(req[7:0]),
    .periph_irq_in(req[8]), .watchdog_reset_in(wd_rst),
    .low_voltage_detector_in(lvd), .clock_monitor_in(clkmon),
    .in_service_in(in_srv), .higher_prio_in(hi_prio),
    .async_serial_ext_clock_sel_in(a_sel),
    .clocked_serial_ext_clock_sel_in(c_sel), .main_osc_en_out(main_en),
    .sub_osc_en_out(sub_en), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .sub_periph_clk_en_out(sper_en),
    .async_serial_ch0_clk_en_out(ch0_en),
    .async_serial_other_clk_en_out(oth_en), .two_wire_clk_en_out(tw_en),
    .clocked_serial_channels_clk_en_out(csi_en),
    .converter_hold_out(conv_h), .port_hold_out(port_h),
    .data_retain_out(retain), .internal_reset_out(int_rst),
    .irq_ack_grant_out(grant), .irq_ack_defer_out(defer));

  sic_irq_model sic_irq_model_inst (.clk_in(clk), .rst_n_in(rst_n),
    .raise_in(raise), .clear_in(clr), .grant_in(grant), .req_out(req));

  always #20 clk = ~clk;

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  task automatic stop_req(input logic [7:0] d);
    wr_reg(4'h4, d);
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic fire(input logic [10:0] v);
    @(posedge clk);
    raise <= v;
    @(posedge clk);
    raise <= 11'h0;
  endtask

  task automatic wait_run();
    n = 0;
    #1;
    while (cpu_en !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    `CHK("reset_wait", 1'b1, n >= RST_WAIT && n <= RST_WAIT + 6)
    rd_chk("mode_sel", 4'h0, 8'h00);
    rd_chk("stab_sel", 4'h8, 8'h06);
    rd_chk("unmapped", 4'h2, 8'h00);
    stop_req(8'h02);
    `CHK("sel00_ignored", 1'b1, cpu_en)
    // Stabilization select set to 02 before deep idle entry
    wr_reg(4'h8, 8'h02);
    wr_reg(4'h0, 8'h02);
    stop_req(8'h02);
    `CHK("deep_idle", 8'ha7, {main_en, cpu_en, ch0_en, oth_en, tw_en, conv_h,
         port_h, retain})
    `CHK("csi_en", c_sel, csi_en)
    a_sel <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("ch0_ext_off", 1'b0, ch0_en)
    a_sel <= 1'b1;
    fire(11'h008);
    wait_run();
    `CHK("idle_wake", 1'b1, n >= 4 && n <= 10)
    `CHK("ack_idle", 2'b10, {grant, defer})
    @(posedge clk);
    #1;
    `CHK("grant_taken", 11'h0, req)
    // Every source masked and the clock monitor pulsing: stop must hold
    wr_reg(4'h0, 8'h03);
    stop_req(8'h72);
    clkmon <= 1'b1;
    fire(11'h7ff);
    clkmon <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK("stop_held", 6'h07, {main_en, cpu_en, per_en, sub_en, sper_en,
         retain})
    @(posedge clk);
    wd_rst <= 1'b1;
    @(posedge clk);
    wd_rst <= 1'b0;
    #1;
    `CHK("int_reset", 1'b1, int_rst)
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_run();
    `CHK("reset_wake", 1'b1, n >= RST_WAIT - 2 && n <= RST_WAIT + 8)
    rd_chk("stab_back", 4'h8, 8'h06);
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h8, 8'h03);
    in_srv <= 1'b1;
    stop_req(8'h02);
    `CHK("stop_osc", 1'b0, main_en)
    fire(11'h100);
    wait_run();
    `CHK("stop_wake", 1'b1, n >= 8 && n <= 14)
    `CHK("ack_defer", 2'b01, {grant, defer})
    `CHK("deferred_kept", 1'b1, req[8])
    rd_chk("status", 4'hc, 8'h20);
    wr_reg(4'h4, 8'h02);
    repeat (4) begin
      @(posedge clk);
      #1;
      `CHK("pending_wake", 1'b1, main_en)
    end
    wait_run();
    hi_prio <= 1'b1;
    stop_req(8'h02);
    wait_run();
    `CHK("ack_high", 2'b10, {grant, defer})
    @(posedge clk);
    #1;
    `CHK("grant_high", 1'b0, req[8])
    lvd <= 1'b1;
    @(posedge clk);
    lvd <= 1'b0;
    #1;
    `CHK("lvd_reset", 1'b1, int_rst)
    wait_run();
    `CHK("lvd_wait", 1'b1, n >= RST_WAIT && n <= RST_WAIT + 8)
    results();
  end
endmodule // sic_standby_ctrl_tb
